// >>> verilog/cpu_register_set_mapping.sv
`timescale 1ns/10ps
// What this block does
// - Addresses span one linear megabyte for data and instruction use.
// - Placement operand 0 puts data areas at 0F700H, operand 0FH at FF700H.
// - Each bank has sixteen byte registers, pairable into 16-bit ones.
// - Four pairs with a byte extension form 24-bit address pointers.
// - Eight banks exist, chosen by software or by context switch.
// - General registers live in RAM; the four extensions live outside it.
// - With the alias select bit at 1, legacy names reach R4-R7, pairs 2-3.
// - The program counter is 20 bits and advances with execution.
// - The status word holds core state and execution updates it.
// - The stack pointer is a 24-bit register holding the stack start.
// - Peripheral registers sit in the top 256 bytes of the data area.
module cpu_register_set_mapping
    import cpu_regs_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic data_area_place_instr,
    input wire logic [3:0] place_operand,
    input wire logic [19:0] access_addr,
    input wire reg_req_t reg_req,
    input wire logic [3:0] rd_index,
    input wire logic rd_word,
    input wire logic rd_legacy,
    input wire logic pc_advance,
    input wire logic [2:0] pc_step,
    input wire logic pc_load,
    input wire logic [19:0] pc_value,
    input wire logic sw_update,
    input wire logic [15:0] sw_value,
    input wire logic ctx_switch,
    input wire logic [2:0] ctx_bank,
    output logic [15:0] rd_data,
    output logic [23:0] ptr_addr,
    output logic [19:0] program_counter,
    output logic [15:0] status_word,
    output logic [23:0] stack_pointer,
    output logic placement_locked,
    output logic placement_high,
    output logic in_data_area,
    output logic in_periph_area
);
    logic locked;
    logic high;
    logic [15:0] sw;
    logic [19:0] pc;
    logic [23:0] sp;
    logic [7:0] ext [PTR_COUNT];
    logic [15:0] rd_q;
    logic [23:0] ptr_q;
    logic in_area_q;
    logic in_periph_q;
    ram_req_t ram_req;
    logic [15:0] ram_rdata;

    // Remap a register index through the legacy alias when requested.
    function automatic logic [3:0] map_index(input logic [3:0] idx,
                                             input logic legacy,
                                             input logic word,
                                             input logic alias_on);
        logic [3:0] r;
        r = idx;
        if (legacy && alias_on) begin
            if (word) begin
                r = {1'b0, ALIAS_BASE_PAIR + idx[2:0]};
            end else begin
                r = ALIAS_BASE_REG + {2'b00, idx[1:0]};
            end
        end
        return r;
    endfunction : map_index

    // Byte address in the shared RAM of a register of the active bank.
    function automatic logic [6:0] ram_slot(input logic [2:0] bank,
                                            input logic [3:0] idx,
                                            input logic word);
        logic [3:0] b;
        b = word ? {idx[2:0], 1'b0} : idx;
        return {bank, b};
    endfunction : ram_slot

    // Test whether an address falls in [base, base + size).
    function automatic logic in_range(input logic [19:0] a,
                                      input logic [19:0] base,
                                      input logic [19:0] size);
        return (a >= base) && ((a - base) < size);
    endfunction : in_range

    wire alias_on = sw[SW_ALIAS_BIT];
    wire [2:0] bank = sw[SW_BANK_LSB +: 3];
    wire is_wr = reg_req.op == OP_WR8 || reg_req.op == OP_WR16;
    wire wr_word = reg_req.op == OP_WR16;
    wire [3:0] wr_idx = map_index(reg_req.index, reg_req.legacy, wr_word,
                                  alias_on);
    wire [3:0] rd_idx = map_index(rd_index, rd_legacy, rd_word,
                                  alias_on);
    wire [6:0] wr_slot = ram_slot(bank, wr_idx, wr_word);
    wire [6:0] rd_slot = ram_slot(bank, rd_idx, rd_word);

    // Writes take the RAM port; reads use it only in write-free cycles.
    assign ram_req.valid = 1'b1;
    assign ram_req.write = is_wr;
    assign ram_req.index = is_wr ? wr_slot : rd_slot;
    assign ram_req.data = reg_req.data[15:0];
    assign ram_req.word = is_wr ? wr_word : rd_word;

    reg_ram u_ram (
        .clk(clk),
        .req(ram_req),
        .rdata(ram_rdata)
    );

    // Pointer pairs 4..7 take extensions 0..3 held in flip-flops.
    wire rd_ptr = rd_word && rd_idx[2];
    wire [1:0] ptr_sel = rd_idx[1:0];
    wire [23:0] next_ptr = {ext[ptr_sel], ram_rdata};

    // Placement decode from the current mapping.
    wire [19:0] area_base = high ? AREA_HIGH_BASE : AREA_LOW_BASE;
    wire [19:0] periph_base = high ? PERIPH_HIGH_BASE
                                   : PERIPH_LOW_BASE;
    wire next_in_area = in_range(access_addr, area_base, AREA_SIZE);
    wire next_in_periph = in_range(access_addr, periph_base,
                                   PERIPH_SIZE);
    wire take_place = data_area_place_instr && !locked;
    wire next_high = place_operand == PLACE_OP_HIGH;

    // Placement latches once per reset; later instructions are ignored.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            locked <= 1'b0;
            high <= 1'b0;
        end else if (take_place) begin
            locked <= 1'b1;
            high <= next_high;
        end
    end

    // Program counter wraps inside the 1M-byte space.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pc <= PC_RESET;
        end else if (pc_load) begin
            pc <= pc_value;
        end else if (pc_advance) begin
            pc <= pc + {17'h00000, pc_step};
        end
    end

    // Status word: execution update, software write, context switch.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sw <= SW_RESET;
        end else if (ctx_switch) begin
            sw[SW_BANK_LSB +: 3] <= ctx_bank;
        end else if (reg_req.op == OP_WR_SW) begin
            sw <= reg_req.data[15:0];
        end else if (reg_req.op == OP_SEL_BANK) begin
            sw[SW_BANK_LSB +: 3] <= reg_req.data[2:0];
        end else if (sw_update) begin
            sw <= sw_value;
        end
    end

    // Stack pointer keeps its top nibble at zero even if software errs.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sp <= SP_RESET;
        end else if (reg_req.op == OP_WR_SP) begin
            sp <= {SP_TOP_ZERO, reg_req.data[19:0]};
        end
    end

    // Extension registers sit outside the RAM so pointers read in one cycle.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < PTR_COUNT; i++) begin
                ext[i] <= 8'h00;
            end
        end else if (reg_req.op == OP_WR_EXT) begin
            ext[reg_req.index[1:0]] <= reg_req.data[7:0];
        end
    end

    // Registered read and decode outputs.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_q <= 16'h0000;
            ptr_q <= 24'h000000;
            in_area_q <= 1'b0;
            in_periph_q <= 1'b0;
        end else begin
            rd_q <= ram_rdata;
            ptr_q <= rd_ptr ? next_ptr : 24'h000000;
            in_area_q <= next_in_area;
            in_periph_q <= next_in_periph;
        end
    end

    assign rd_data = rd_q;
    assign ptr_addr = ptr_q;
    assign program_counter = pc;
    assign status_word = sw;
    assign stack_pointer = sp;
    assign placement_locked = locked;
    assign placement_high = high;
    assign in_data_area = in_area_q;
    assign in_periph_area = in_periph_q;
endmodule : cpu_register_set_mapping

// >>> inc/cpu_regs_pkg.sv
package cpu_regs_pkg;

    // Address space and data-area placement.
    localparam int ADDR_W = 20;
    localparam logic [19:0] AREA_LOW_BASE = 20'h0F700;
    localparam logic [19:0] AREA_HIGH_BASE = 20'hFF700;
    localparam logic [19:0] AREA_SIZE = 20'h00900;
    localparam logic [19:0] PERIPH_LOW_BASE = 20'h0FF00;
    localparam logic [19:0] PERIPH_HIGH_BASE = 20'hFFF00;
    localparam logic [19:0] PERIPH_SIZE = 20'h00100;
    localparam logic [3:0] PLACE_OP_LOW = 4'h0;
    localparam logic [3:0] PLACE_OP_HIGH = 4'hF;

    // Register file geometry.
    localparam int BANKS = 8;
    localparam int REGS_PER_BANK = 16;
    localparam int RAM_WORDS = BANKS * REGS_PER_BANK;
    localparam int PTR_COUNT = 4;
    localparam int SP_W = 24;
    localparam int SW_W = 16;

    // Status word field positions and reset values.
    localparam int SW_ALIAS_BIT = 5;
    localparam int SW_BANK_LSB = 12;
    localparam logic [15:0] SW_RESET = 16'h0000;
    localparam logic [19:0] PC_RESET = 20'h00000;
    localparam logic [23:0] SP_RESET = 24'h000000;
    localparam logic [3:0] SP_TOP_ZERO = 4'h0;

    // Legacy alias codes used when the alias select bit is set.
    localparam logic [3:0] ALIAS_BASE_REG = 4'h4;
    localparam logic [2:0] ALIAS_BASE_PAIR = 3'h2;

    // Pointer to extension register: pair 4..7 use extensions 0..3.
    localparam logic [2:0] PTR_PAIR_BASE = 3'h4;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_WR8,
        OP_WR16,
        OP_WR_EXT,
        OP_WR_SP,
        OP_WR_SW,
        OP_SEL_BANK
    } reg_op_t;

    typedef struct packed {
        reg_op_t op;
        logic legacy;
        logic [3:0] index;
        logic [23:0] data;
    } reg_req_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [6:0] index;
        logic [15:0] data;
        logic word;
    } ram_req_t;

endpackage : cpu_regs_pkg

// >>> verilog/reg_ram.sv
`timescale 1ns/10ps
module reg_ram
    import cpu_regs_pkg::*;
(
    input wire logic clk,
    input wire ram_req_t req,
    output logic [15:0] rdata
);
    logic [7:0] mem [RAM_WORDS];
    logic [6:0] upper_index;

    // A pair occupies an even byte and the byte above it.
    assign upper_index = req.index | 7'h01;

    // Byte storage; the pair write touches both bytes in one edge.
    always_ff @(posedge clk) begin
        if (req.valid && req.write) begin
            mem[req.index] <= req.data[7:0];
            if (req.word) begin
                mem[upper_index] <= req.data[15:8];
            end
        end
    end

    // Combinational read of the addressed byte or pair.
    assign rdata = req.word ? {mem[upper_index], mem[req.index]}
                            : {8'h00, mem[req.index]};
endmodule : reg_ram

// >>> verification/cpu_register_set_mapping_checker.sv
`timescale 1ns/10ps
module cpu_register_set_mapping_checker
    import cpu_regs_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic data_area_place_instr,
    input wire logic [3:0] place_operand,
    input wire logic [19:0] access_addr,
    input wire reg_req_t reg_req,
    input wire logic pc_advance,
    input wire logic [2:0] pc_step,
    input wire logic pc_load,
    input wire logic [19:0] pc_value,
    input wire logic ctx_switch,
    input wire logic [2:0] ctx_bank,
    input wire logic [19:0] program_counter,
    input wire logic [15:0] status_word,
    input wire logic [23:0] stack_pointer,
    input wire logic placement_locked,
    input wire logic placement_high,
    input wire logic in_data_area,
    input wire logic in_periph_area
);
    // One clock domain, so clocking and reset are given once for all.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Bases follow the placement, which no longer moves once locked.
    wire logic [19:0] area_base = placement_high ? AREA_HIGH_BASE
                                                 : AREA_LOW_BASE;
    wire logic [19:0] per_base = placement_high ? PERIPH_HIGH_BASE
                                                : PERIPH_LOW_BASE;
    property p_lock_first;
        data_area_place_instr && !placement_locked |=> placement_locked &&
            placement_high == ($past(place_operand) == PLACE_OP_HIGH);
    endproperty
    a_lock_first: assert property (p_lock_first)
        else $error("bad placement");
    property p_lock_keep;
        placement_locked |=> placement_locked && $stable(placement_high);
    endproperty
    a_lock_keep: assert property (p_lock_keep)
        else $error("placement moved");
    property p_no_lock;
        !placement_locked && !data_area_place_instr |=> !placement_locked;
    endproperty
    a_no_lock: assert property (p_no_lock)
        else $error("stray lock");
    property p_area;
        placement_locked |=>
            in_data_area == ($past(access_addr) - area_base < AREA_SIZE);
    endproperty
    a_area: assert property (p_area)
        else $error("data area decode");
    property p_periph;
        placement_locked |=>
            in_periph_area == ($past(access_addr) - per_base < PERIPH_SIZE);
    endproperty
    a_periph: assert property (p_periph)
        else $error("periph decode");
    property p_pc_load;
        pc_load |=> program_counter == $past(pc_value);
    endproperty
    a_pc_load: assert property (p_pc_load)
        else $error("pc load");
    property p_pc_step;
        pc_advance && !pc_load |=>
            program_counter == 20'($past(program_counter) + $past(pc_step));
    endproperty
    a_pc_step: assert property (p_pc_step)
        else $error("pc step");
    property p_sp;
        reg_req.op == OP_WR_SP |=>
            stack_pointer == {SP_TOP_ZERO, $past(reg_req.data[19:0])};
    endproperty
    a_sp: assert property (p_sp)
        else $error("sp write");
    property p_sp_hold;
        reg_req.op != OP_WR_SP |=> $stable(stack_pointer);
    endproperty
    a_sp_hold: assert property (p_sp_hold)
        else $error("sp changed");
    property p_ctx;
        ctx_switch |=> status_word[SW_BANK_LSB +: 3] == $past(ctx_bank);
    endproperty
    a_ctx: assert property (p_ctx)
        else $error("bank switch");
    c_high: cover property (data_area_place_instr &&
                            place_operand == PLACE_OP_HIGH);
    c_periph: cover property (in_periph_area);
    c_ctx: cover property (ctx_switch);
endmodule : cpu_register_set_mapping_checker

bind cpu_register_set_mapping cpu_register_set_mapping_checker u_chk (
    .clk(clk), .sys_rst(sys_rst), .access_addr(access_addr),
    .data_area_place_instr(data_area_place_instr), .reg_req(reg_req),
    .place_operand(place_operand), .pc_advance(pc_advance),
    .pc_step(pc_step), .pc_load(pc_load), .pc_value(pc_value),
    .ctx_switch(ctx_switch), .ctx_bank(ctx_bank),
    .program_counter(program_counter), .status_word(status_word),
    .stack_pointer(stack_pointer), .placement_locked(placement_locked),
    .placement_high(placement_high), .in_data_area(in_data_area),
    .in_periph_area(in_periph_area));

// >>> verification/cpu_register_set_mapping_tb_top.sv
`timescale 1ns/10ps
module cpu_register_set_mapping_tb_top
    import cpu_regs_pkg::*;
;
    logic clk, sys_rst, place, rd_word, rd_legacy, pc_advance, pc_load;
    logic sw_update, ctx_switch, locked, high, in_area, in_per;
    logic [3:0] operand, rd_index;
    logic [19:0] addr, pc_value, pc;
    logic [2:0] pc_step, ctx_bank;
    logic [15:0] sw_value, rd_data, sw;
    logic [23:0] ptr, sp;
    reg_req_t req;
    int mismatches = 0;
    int comparisons = 0;
    cpu_register_set_mapping dut (.clk(clk), .sys_rst(sys_rst),
        .data_area_place_instr(place), .place_operand(operand),
        .access_addr(addr), .reg_req(req), .rd_index(rd_index),
        .rd_word(rd_word), .rd_legacy(rd_legacy), .pc_advance(pc_advance),
        .pc_step(pc_step), .pc_load(pc_load), .pc_value(pc_value),
        .sw_update(sw_update), .sw_value(sw_value),
        .ctx_switch(ctx_switch), .ctx_bank(ctx_bank), .rd_data(rd_data),
        .ptr_addr(ptr), .program_counter(pc), .status_word(sw),
        .stack_pointer(sp), .placement_locked(locked),
        .placement_high(high), .in_data_area(in_area),
        .in_periph_area(in_per));
    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task stop_test;
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    task chk(string nm, logic [23:0] exp, logic [23:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Inputs move 1 ns after the edge so no race with the design's flops.
    task cyc;
        @(posedge clk);
        #1;
    endtask : cyc
    task wr(reg_op_t op, logic lg, logic [3:0] ix, logic [23:0] d);
        req = {op, lg, ix, d};
        cyc;
        req = '0;
        // An idle edge keeps back-to-back calls from driving req twice.
        cyc;
    endtask : wr
    task rd(logic [3:0] ix, logic w, logic lg, logic [15:0] e);
        rd_index = ix;
        rd_word = w;
        rd_legacy = lg;
        cyc;
        chk("rd_data", {8'h00, e}, {8'h00, rd_data});
    endtask : rd
    task do_place(logic [3:0] op);
        place = 1'b1;
        operand = op;
        cyc;
        place = 1'b0;
        // Let the strobe fall for one edge before any further pulse.
        cyc;
    endtask : do_place
    task dec(logic [19:0] a, logic d, logic p);
        addr = a;
        cyc;
        chk("in_data_area", {23'h0, d}, {23'h0, in_area});
        chk("in_periph_area", {23'h0, p}, {23'h0, in_per});
    endtask : dec
    task t_place(logic [3:0] op, logic [19:0] top, logic [19:0] other);
        chk("locked", 24'h0, {23'h0, locked});
        do_place(op);
        do_place(op ^ 4'hF);
        chk("high", {23'h0, op == 4'hF}, {23'h0, high});
        dec(top | 20'h00F10, 1'b1, 1'b1);
        dec(top | 20'h00700, 1'b1, 1'b0);
        dec(top | 20'h006FF, 1'b0, 1'b0);
        dec(other | 20'h00F10, 1'b0, 1'b0);
    endtask : t_place
    task t_regs;
        wr(OP_WR8, 1'b0, 4'h0, 24'h12);
        wr(OP_WR8, 1'b0, 4'h1, 24'h34);
        rd(4'h0, 1'b1, 1'b0, 16'h3412);
        wr(OP_WR16, 1'b0, 4'h3, 24'hABCD);
        rd(4'h7, 1'b0, 1'b0, 16'h00AB);
        chk("ptr_addr", 24'h000000, ptr);
        ctx_switch = 1'b1;
        ctx_bank = 3'h1;
        cyc;
        ctx_switch = 1'b0;
        wr(OP_WR16, 1'b0, 4'h0, 24'h5555);
        rd(4'h0, 1'b1, 1'b0, 16'h5555);
        ctx_switch = 1'b1;
        ctx_bank = 3'h0;
        cyc;
        ctx_switch = 1'b0;
        rd(4'h0, 1'b1, 1'b0, 16'h3412);
        sw_update = 1'b1;
        sw_value = 16'h0020;
        cyc;
        sw_update = 1'b0;
        chk("status_word", 24'h000020, {8'h00, sw});
        wr(OP_WR16, 1'b0, 4'h2, 24'hC35A);
        wr(OP_WR8, 1'b1, 4'h1, 24'h77);
        rd(4'h0, 1'b0, 1'b1, 16'h005A);
        rd(4'h0, 1'b1, 1'b1, 16'h775A);
        wr(OP_WR16, 1'b0, 4'h4, 24'h1234);
        wr(OP_WR_EXT, 1'b0, 4'h0, 24'h56);
        rd(4'h4, 1'b1, 1'b0, 16'h1234);
        chk("ptr_addr", 24'h561234, ptr);
        wr(OP_SEL_BANK, 1'b0, 4'h0, 24'h000002);
        chk("status_word", 24'h002020, {8'h00, sw});
        wr(OP_WR_SW, 1'b0, 4'h0, 24'h000000);
        chk("status_word", 24'h000000, {8'h00, sw});
    endtask : t_regs
    task t_ctrl;
        wr(OP_WR_SP, 1'b0, 4'h0, 24'hFABCDE);
        chk("stack_pointer", 24'h0ABCDE, sp);
        wr(OP_WR_SP, 1'b0, 4'h0, 24'h012345);
        chk("stack_pointer", 24'h012345, sp);
        pc_load = 1'b1;
        pc_value = 20'hFFFFE;
        cyc;
        pc_load = 1'b0;
        pc_advance = 1'b1;
        pc_step = 3'h3;
        cyc;
        pc_advance = 1'b0;
        chk("program_counter", 24'h000001, {4'h0, pc});
    endtask : t_ctrl
    // Main sequence; a second reset checks the low placement afresh.
    initial begin
        {place, rd_word, rd_legacy, pc_advance, pc_load} = '0;
        {sw_update, ctx_switch, operand, rd_index, addr} = '0;
        {pc_value, pc_step, ctx_bank, sw_value, req} = '0;
        sys_rst = 1'b1;
        repeat (10) cyc;
        sys_rst = 1'b0;
        t_place(4'hF, 20'hFF000, 20'h0F000);
        t_regs;
        t_ctrl;
        sys_rst = 1'b1;
        cyc;
        sys_rst = 1'b0;
        t_place(4'h0, 20'h0F000, 20'hFF000);
        stop_test;
    end
    // The run needs under 100 cycles, so 2000 means a hang.
    initial begin
        repeat (2000) @(posedge clk);
        mismatches++;
        stop_test;
    end
endmodule : cpu_register_set_mapping_tb_top
